// ===== inc/port_pkg.sv
// Register map, field layout, reset values and carrier types of the port pin block.
// Notes on behaviour
// R01 - Pull enable bits switch on a pull device for input pins; none after reset.
// R02 - A pull enable bit does nothing while its pin is an output.
// R03 - Polarity 0: falling edge sets the flag; enabled pull pulls up.
// R04 - Polarity 1: rising edge sets the flag; enabled pull pulls down.
// R05 - Each interrupt enable bit masks (0) or passes (1) its own flag.
// R06 - A flag is set by the selected active edge and stays until cleared.
// R07 - Writing 1 clears a flag; bits written with 0 are left alone.
// R08 - Interrupt request is high while any enabled flag is set.
// R09 - Data_j reads the stored bit for outputs, the pin level for inputs.
// R10 - Pin_input_j always reads the pin levels and ignores writes.
// R11 - Direction_j bits 7 and 6: 0 makes the pin input, 1 output.
// R12 - Reads may be stale up to two cycles after a direction change.
// R13 - Direction_p bit 0 is input, 1 output; it gates the pull devices.
// R14 - Bits 5 to 0 of the port j registers read 0 and ignore writes.
// R15 - Pins are synchronised before edge detection; one flag set per transition.
`default_nettype none

package port_pkg;

    localparam int P_WIDTH = 8;
    localparam int J_MSB   = 7;
    localparam int J_LSB   = 6;
    localparam int J_WIDTH = J_MSB - J_LSB + 1;

    // Printed offsets are register indices; each register takes one word.
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx[5:0], 2'b00};
    endfunction : reg_addr

    localparam logic [7:0] IDX_PULL_EN_P   = 8'h1C;
    localparam logic [7:0] IDX_POLARITY_P  = 8'h1D;
    localparam logic [7:0] IDX_IRQ_EN_P    = 8'h1E;
    localparam logic [7:0] IDX_FLAGS_P     = 8'h1F;
    localparam logic [7:0] IDX_DATA_J      = 8'h28;
    localparam logic [7:0] IDX_PIN_INPUT_J = 8'h29;
    localparam logic [7:0] IDX_DIRECTION_J = 8'h2A;

    localparam logic [7:0] ADDR_PULL_EN_P   = reg_addr(IDX_PULL_EN_P);
    localparam logic [7:0] ADDR_POLARITY_P  = reg_addr(IDX_POLARITY_P);
    localparam logic [7:0] ADDR_IRQ_EN_P    = reg_addr(IDX_IRQ_EN_P);
    localparam logic [7:0] ADDR_FLAGS_P     = reg_addr(IDX_FLAGS_P);
    localparam logic [7:0] ADDR_DATA_J      = reg_addr(IDX_DATA_J);
    localparam logic [7:0] ADDR_PIN_INPUT_J = reg_addr(IDX_PIN_INPUT_J);
    localparam logic [7:0] ADDR_DIRECTION_J = reg_addr(IDX_DIRECTION_J);

    localparam logic [P_WIDTH-1:0] RST_PULL_EN_P   = 8'h00;
    localparam logic [P_WIDTH-1:0] RST_POLARITY_P  = 8'h00;
    localparam logic [P_WIDTH-1:0] RST_IRQ_EN_P    = 8'h00;
    localparam logic [P_WIDTH-1:0] RST_FLAGS_P     = 8'h00;
    localparam logic [J_WIDTH-1:0] RST_DATA_J      = 2'h0;
    localparam logic [J_WIDTH-1:0] RST_DIRECTION_J = 2'h0;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       word;
    } bus_req_t;

    typedef struct packed {
        logic [P_WIDTH-1:0] pull_enable;
        logic [P_WIDTH-1:0] polarity;
        logic [P_WIDTH-1:0] irq_enable;
    } port_p_cfg_t;

endpackage : port_pkg

`default_nettype wire

// ===== rtl/edge_flag_unit.sv
// Sticky edge flags with per-bit polarity and write-one-to-clear.
`timescale 1ns/10ps
`default_nettype none

module edge_flag_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] level_in,
    input  wire logic [WIDTH-1:0] polarity_in,
    input  wire logic [WIDTH-1:0] clear_in,
    output logic      [WIDTH-1:0] flags_out
);

    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_prev;
    logic [WIDTH-1:0] flags;
    logic [WIDTH-1:0] next_flags;
    logic [WIDTH-1:0] hit;

    always_comb begin
        // Level is already synchronised, so each transition is seen once. [R15]
        hit = (polarity_in & level_in & ~prev)        // [R04]
            | (~polarity_in & ~level_in & prev);      // [R03]
        // Setting wins over a clear in the same cycle. [R06] [R07]
        next_flags = (flags & ~clear_in) | hit;
        next_prev  = level_in;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev  <= '0;
            flags <= '0;
        end else begin
            prev  <= next_prev;
            flags <= next_flags;
        end
    end

    assign flags_out = flags;

endmodule : edge_flag_unit

`default_nettype wire

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for pin levels entering the bus clock domain.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule : pin_sync

`default_nettype wire

// ===== rtl/port_pin_irq_and_io.sv
// Port block: eight-pin pull, polarity and edge interrupt logic, two-pin I/O port, AHB-Lite slave.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module port_pin_irq_and_io
    import port_pkg::*;
(
    input  wire logic               CLK_IN,
    input  wire logic               RESET_N_IN,
    input  wire logic               HSEL_IN,
    input  wire logic [31:0]        HADDR_IN,
    input  wire logic [1:0]         HTRANS_IN,
    input  wire logic               HWRITE_IN,
    input  wire logic [2:0]         HSIZE_IN,
    input  wire logic [31:0]        HWDATA_IN,
    input  wire logic               HREADY_IN,
    output logic      [31:0]        HRDATA_OUT,
    output logic                    HREADYOUT_OUT,
    output logic                    HRESP_OUT,
    input  wire logic [P_WIDTH-1:0] DIRECTION_P_IN,
    input  wire logic [P_WIDTH-1:0] PIN_P_IN,
    output logic      [P_WIDTH-1:0] PULL_EN_P_OUT,
    output logic      [P_WIDTH-1:0] PULL_DOWN_P_OUT,
    input  wire logic [J_WIDTH-1:0] PIN_J_IN,
    output logic      [J_WIDTH-1:0] PIN_J_OUT,
    output logic      [J_WIDTH-1:0] PIN_J_OE_OUT,
    output logic                    IRQ_OUT
);

    bus_state_t         state;
    bus_state_t         next_state;
    bus_req_t           req;
    bus_req_t           next_req;
    logic [31:0]        hrdata;
    logic [31:0]        next_hrdata;
    logic               hreadyout;
    logic               next_hreadyout;
    logic               start;
    logic               wr_en;
    logic [31:0]        read_data;

    port_p_cfg_t        cfg_p;
    port_p_cfg_t        next_cfg_p;
    logic [J_WIDTH-1:0] data_j;
    logic [J_WIDTH-1:0] next_data_j;
    logic [J_WIDTH-1:0] dir_j;
    logic [J_WIDTH-1:0] next_dir_j;
    logic [P_WIDTH-1:0] clear_p;

    logic [P_WIDTH-1:0] pin_p_sync;
    logic [J_WIDTH-1:0] pin_j_sync;
    logic [P_WIDTH-1:0] flags_p;

    logic [P_WIDTH-1:0] pull_en;
    logic [P_WIDTH-1:0] next_pull_en;
    logic               irq;
    logic               next_irq;

    pin_sync #(
        .WIDTH (P_WIDTH)
    ) u_sync_p (
        .clk_in     (CLK_IN),
        .reset_n_in (RESET_N_IN),
        .async_in   (PIN_P_IN),
        .sync_out   (pin_p_sync)
    );

    // Port j reads lag the pins by the two synchroniser stages. [R12]
    pin_sync #(
        .WIDTH (J_WIDTH)
    ) u_sync_j (
        .clk_in     (CLK_IN),
        .reset_n_in (RESET_N_IN),
        .async_in   (PIN_J_IN),
        .sync_out   (pin_j_sync)
    );

    edge_flag_unit #(
        .WIDTH (P_WIDTH)
    ) u_flags_p (
        .clk_in      (CLK_IN),
        .reset_n_in  (RESET_N_IN),
        .level_in    (pin_p_sync),
        .polarity_in (cfg_p.polarity),
        .clear_in    (clear_p),
        .flags_out   (flags_p)
    );

    // Bus slave. One wait state lets the read data come out of a register.
    assign start = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

    always_comb begin
        next_state     = state;
        next_req       = req;
        next_hrdata    = hrdata;
        next_hreadyout = hreadyout;
        wr_en          = 1'b0;
        case (state)
            ST_IDLE: begin
                next_hreadyout = 1'b1;
                if (start) begin
                    next_req.addr  = HADDR_IN[7:0];
                    next_req.write = HWRITE_IN;
                    next_req.word  = (HSIZE_IN == HSIZE_WORD);
                    next_hreadyout = 1'b0;
                    next_state     = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                next_hreadyout = 1'b1;
                next_hrdata    = req.write ? 32'h0000_0000 : read_data;
                // Narrower writes are ignored; only whole words are used.
                wr_en          = req.write & req.word;
                next_state     = ST_IDLE;
            end
            default: begin
                next_hreadyout = 1'b1;
                next_state     = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state     <= ST_IDLE;
            req       <= '0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
        end else begin
            state     <= next_state;
            req       <= next_req;
            hrdata    <= next_hrdata;
            hreadyout <= next_hreadyout;
        end
    end

    // Register writes, applied at the end of the wait state, one cycle before the data phase ends.
    always_comb begin
        next_cfg_p  = cfg_p;
        next_data_j = data_j;
        next_dir_j  = dir_j;
        clear_p     = '0;
        if (wr_en) begin
            case (req.addr)
                ADDR_PULL_EN_P:   next_cfg_p.pull_enable = HWDATA_IN[P_WIDTH-1:0];
                ADDR_POLARITY_P:  next_cfg_p.polarity    = HWDATA_IN[P_WIDTH-1:0];
                ADDR_IRQ_EN_P:    next_cfg_p.irq_enable  = HWDATA_IN[P_WIDTH-1:0];
                ADDR_FLAGS_P:     clear_p     = HWDATA_IN[P_WIDTH-1:0]; // [R07]
                ADDR_DATA_J:      next_data_j = HWDATA_IN[J_MSB:J_LSB]; // [R09] [R14]
                ADDR_DIRECTION_J: next_dir_j  = HWDATA_IN[J_MSB:J_LSB]; // [R11] [R14]
                default: begin
                    // The pin input register and unmapped words take no write. [R10]
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            cfg_p  <= '{pull_enable: RST_PULL_EN_P,
                        polarity:    RST_POLARITY_P,
                        irq_enable:  RST_IRQ_EN_P}; // [R01]
            data_j <= RST_DATA_J;
            dir_j  <= RST_DIRECTION_J;
        end else begin
            cfg_p  <= next_cfg_p;
            data_j <= next_data_j;
            dir_j  <= next_dir_j;
        end
    end

    // Read multiplexer; bits not listed read as zero.
    always_comb begin
        read_data = 32'h0000_0000;
        case (req.addr)
            ADDR_PULL_EN_P:   read_data[P_WIDTH-1:0] = cfg_p.pull_enable;
            ADDR_POLARITY_P:  read_data[P_WIDTH-1:0] = cfg_p.polarity;
            ADDR_IRQ_EN_P:    read_data[P_WIDTH-1:0] = cfg_p.irq_enable;
            ADDR_FLAGS_P:     read_data[P_WIDTH-1:0] = flags_p; // [R06]
            ADDR_DATA_J:      read_data[J_MSB:J_LSB] =
                                  (dir_j & data_j) | (~dir_j & pin_j_sync); // [R09] [R14]
            ADDR_PIN_INPUT_J: read_data[J_MSB:J_LSB] = pin_j_sync; // [R10] [R14]
            ADDR_DIRECTION_J: read_data[J_MSB:J_LSB] = dir_j; // [R14]
            default:          read_data = 32'h0000_0000;
        endcase
    end

    // Pad control and interrupt request. The pull is only offered to input pins,
    // and the direction input comes from logic on this clock, so it is not synchronised.
    always_comb begin
        next_pull_en = cfg_p.pull_enable & ~DIRECTION_P_IN; // [R01] [R02] [R13]
        next_irq     = |(flags_p & cfg_p.irq_enable);       // [R05] [R08]
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pull_en <= RST_PULL_EN_P;
            irq     <= 1'b0;
        end else begin
            pull_en <= next_pull_en;
            irq     <= next_irq;
        end
    end

    assign HRDATA_OUT      = hrdata;
    assign HREADYOUT_OUT   = hreadyout;
    assign HRESP_OUT       = HRESP_OKAY;
    assign PULL_EN_P_OUT   = pull_en;
    // Polarity 0 selects pull-up, 1 selects pull-down. [R03] [R04]
    assign PULL_DOWN_P_OUT = cfg_p.polarity;
    assign PIN_J_OUT       = data_j;
    assign PIN_J_OE_OUT    = dir_j; // [R11]
    assign IRQ_OUT         = irq;

endmodule : port_pin_irq_and_io

`default_nettype wire

// ===== sim/pin_board.sv
// Board model for the port pins: drivers, pull devices and the port J wires.
`timescale 1ns/10ps
`default_nettype none

module pin_board (
    input  wire logic       clk_in,
    input  wire logic [7:0] drive_p_in,
    input  wire logic [7:0] drive_p_en_in,
    input  wire logic [7:0] pull_en_in,
    input  wire logic [7:0] pull_down_in,
    input  wire logic [1:0] j_out_in,
    input  wire logic [1:0] j_oe_in,
    input  wire logic [1:0] j_ext_in,
    output logic      [7:0] pin_p_out,
    output logic      [1:0] pin_j_out
);
    logic [7:0] last = 8'h00;

    always @(posedge clk_in) begin
        last <= pin_p_out;
    end
    // A floating pin without a pull flips every cycle, so a stale level never looks valid.
    assign pin_p_out = (drive_p_en_in & drive_p_in)
                     | (~drive_p_en_in & pull_en_in & ~pull_down_in)
                     | (~drive_p_en_in & ~pull_en_in & ~last);
    assign pin_j_out = (j_oe_in & j_out_in) | (~j_oe_in & j_ext_in);
endmodule : pin_board

`default_nettype wire

// ===== sim/port_pin_chk.sv
// Assertion checker for the port pin block's top-level ports.
`timescale 1ns/10ps
`default_nettype none

module port_pin_chk
    import port_pkg::*;
(
    input  wire logic               CLK_IN,
    input  wire logic               RESET_N_IN,
    input  wire logic               HSEL_IN,
    input  wire logic [1:0]         HTRANS_IN,
    input  wire logic               HREADY_IN,
    input  wire logic [31:0]        HRDATA_OUT,
    input  wire logic               HREADYOUT_OUT,
    input  wire logic [P_WIDTH-1:0] DIRECTION_P_IN,
    input  wire logic [P_WIDTH-1:0] PIN_P_IN,
    input  wire logic [P_WIDTH-1:0] PULL_EN_P_OUT,
    input  wire logic [P_WIDTH-1:0] PULL_DOWN_P_OUT,
    input  wire logic [J_WIDTH-1:0] PIN_J_OUT,
    input  wire logic [J_WIDTH-1:0] PIN_J_OE_OUT,
    input  wire logic               IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    pull_gate_a: assert property ((PULL_EN_P_OUT & $past(DIRECTION_P_IN)) == 8'h00)
        else $error("pull enabled on an output pin");
    pull_reset_a: assert property ($rose(RESET_N_IN) |-> PULL_EN_P_OUT == 8'h00)
        else $error("pull enabled after reset");
    pull_sel_a: assert property (!$stable(PULL_DOWN_P_OUT) |-> $past(!HREADYOUT_OUT))
        else $error("pull direction moved without a write");
    dir_j_a: assert property (!$stable(PIN_J_OE_OUT) |-> $past(!HREADYOUT_OUT))
        else $error("port j enable moved without a write");
    out_j_a: assert property (!$stable(PIN_J_OUT) |-> $past(!HREADYOUT_OUT))
        else $error("port j output moved without a write");
    irq_rise_a: assert property ($rose(IRQ_OUT) |->
        $past(!HREADYOUT_OUT, 2) || $past(PIN_P_IN, 3) != $past(PIN_P_IN, 6))
        else $error("interrupt rose without edge or write");
    irq_fall_a: assert property ($fell(IRQ_OUT) |-> $past(!HREADYOUT_OUT, 2))
        else $error("interrupt fell without a write");
    bus_wait_a: assert property (HSEL_IN && HTRANS_IN[1] && HREADY_IN && HREADYOUT_OUT
        |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
        else $error("transfer not answered after one wait");
    read_hold_a: assert property (!$stable(HRDATA_OUT) |-> $past(!HREADYOUT_OUT))
        else $error("read data moved outside a transfer");
endmodule : port_pin_chk

bind port_pin_irq_and_io port_pin_chk i_chk (.CLK_IN, .RESET_N_IN, .HSEL_IN, .HTRANS_IN,
    .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT, .DIRECTION_P_IN, .PIN_P_IN, .PULL_EN_P_OUT,
    .PULL_DOWN_P_OUT, .PIN_J_OUT, .PIN_J_OE_OUT, .IRQ_OUT);

`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the port pin block with a board model on its pins.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import port_pkg::*;
    logic        CLK_IN = 1'b0;
    logic        RESET_N_IN = 1'b0;
    logic        HSEL_IN = 1'b0;
    logic [31:0] HADDR_IN = 32'h0;
    logic [1:0]  HTRANS_IN = 2'h0;
    logic        HWRITE_IN = 1'b0;
    logic [2:0]  HSIZE_IN = 3'h0;
    logic [31:0] HWDATA_IN = 32'h0;
    logic [7:0]  DIRECTION_P_IN = 8'h00;
    logic        HREADY_IN, HREADYOUT_OUT, HRESP_OUT, IRQ_OUT;
    logic [31:0] HRDATA_OUT;
    logic [7:0]  PIN_P_IN, PULL_EN_P_OUT, PULL_DOWN_P_OUT, drv_p = 8'h00, drv_en = 8'hFF;
    logic [1:0]  PIN_J_IN, PIN_J_OUT, PIN_J_OE_OUT, ext_j = 2'h0;
    logic [31:0] v, w;
    logic [7:0]  fl, pol, nw, ie;
    int          fails = 0;
    int          n_checks = 0;
    logic [7:0]  regs[7] = '{ADDR_PULL_EN_P, ADDR_POLARITY_P, ADDR_IRQ_EN_P, ADDR_FLAGS_P,
                            ADDR_DATA_J, ADDR_PIN_INPUT_J, ADDR_DIRECTION_J};

    assign HREADY_IN = HREADYOUT_OUT;
    initial begin
        forever #20 CLK_IN = ~CLK_IN;
    end
    port_pin_irq_and_io i_dut (.CLK_IN, .RESET_N_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN, .HWRITE_IN,
        .HSIZE_IN, .HWDATA_IN, .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT,
        .DIRECTION_P_IN, .PIN_P_IN, .PULL_EN_P_OUT, .PULL_DOWN_P_OUT, .PIN_J_IN, .PIN_J_OUT,
        .PIN_J_OE_OUT, .IRQ_OUT);
    pin_board i_board (.clk_in(CLK_IN), .drive_p_in(drv_p), .drive_p_en_in(drv_en),
        .pull_en_in(PULL_EN_P_OUT), .pull_down_in(PULL_DOWN_P_OUT), .j_out_in(PIN_J_OUT),
        .j_oe_in(PIN_J_OE_OUT), .j_ext_in(ext_j), .pin_p_out(PIN_P_IN), .pin_j_out(PIN_J_IN));

    function automatic logic [7:0] hits(input logic [7:0] p, input logic [7:0] o,
                                        input logic [7:0] n);
        return (p & ~o & n) | (~p & o & ~n);
    endfunction : hits

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // Waits are unbounded here on purpose; the watchdog cuts a hung slave short.
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                        output logic [31:0] rd);
        HSEL_IN   <= 1'b1;
        HADDR_IN  <= {24'h0, a};
        HWRITE_IN <= we;
        HSIZE_IN  <= HSIZE_WORD;
        HTRANS_IN <= HTRANS_NONSEQ;
        do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
        HTRANS_IN <= 2'h0;
        HWDATA_IN <= d;
        do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
        rd = HRDATA_OUT;
        chk("response", 32'(HRESP_OKAY), 32'(HRESP_OUT));
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        xfer(a, 1'b1, d, rd);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] rd;
        xfer(a, 1'b0, 32'h0, rd);
        chk(nm, e, rd);
    endtask : rchk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge CLK_IN);
        fails++;
        wrap_up();
    end

    initial begin
        void'($urandom(14));
        repeat (12) @(posedge CLK_IN);
        RESET_N_IN <= 1'b1;
        @(posedge CLK_IN);
        foreach (regs[k]) rchk("reset value", regs[k], 32'h0);
        rchk("unmapped", 8'h00, 32'h0);
        $display("test reset done");
        drv_en <= 8'h00;
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            w = (i == 0) ? 32'hFF : $urandom;
            DIRECTION_P_IN <= (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
            wr(ADDR_PULL_EN_P, v);
            wr(ADDR_POLARITY_P, w);
            rchk("pull enable", ADDR_PULL_EN_P, 32'(v[7:0]));
            rchk("polarity", ADDR_POLARITY_P, 32'(w[7:0]));
            chk("pull out", 32'(v[7:0] & ~DIRECTION_P_IN), 32'(PULL_EN_P_OUT));
            chk("pull down", 32'(w[7:0]), 32'(PULL_DOWN_P_OUT));
        end
        $display("test pull done");
        drv_en <= 8'hFF;
        repeat (8) @(posedge CLK_IN);
        wr(ADDR_FLAGS_P, 32'hFF);
        fl = 8'h00;
        for (int i = 0; i < 12; i++) begin
            pol = (i < 2) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom);
            ie = (i == 0) ? 8'h00 : 8'($urandom);
            nw = (i < 3) ? ~drv_p : 8'($urandom);
            wr(ADDR_POLARITY_P, 32'(pol));
            wr(ADDR_IRQ_EN_P, 32'(ie));
            fl = fl | hits(pol, drv_p, nw);
            drv_p <= nw;
            repeat (6) @(posedge CLK_IN);
            rchk("flags", ADDR_FLAGS_P, 32'(fl));
            chk("irq", 32'(|(fl & ie)), 32'(IRQ_OUT));
            w = $urandom;
            wr(ADDR_FLAGS_P, w);
            fl = fl & ~w[7:0];
            rchk("flags clear", ADDR_FLAGS_P, 32'(fl));
            @(posedge CLK_IN);
            chk("irq clear", 32'(|(fl & ie)), 32'(IRQ_OUT));
        end
        $display("test edges done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            w = $urandom;
            ext_j <= 2'($urandom);
            wr(ADDR_DATA_J, v);
            wr(ADDR_DIRECTION_J, w);
            wr(ADDR_PIN_INPUT_J, ~v);
            repeat (3) @(posedge CLK_IN);
            nw = {(w[7:6] & v[7:6]) | (~w[7:6] & ext_j), 6'h00};
            rchk("data j", ADDR_DATA_J, 32'(nw));
            rchk("input j", ADDR_PIN_INPUT_J, 32'(nw));
            rchk("direction j", ADDR_DIRECTION_J, 32'({w[7:6], 6'h00}));
            chk("oe j", 32'(w[7:6]), 32'(PIN_J_OE_OUT));
            chk("out j", 32'(v[7:6]), 32'(PIN_J_OUT));
        end
        $display("test port j done");
        RESET_N_IN <= 1'b0;
        repeat (2) @(posedge CLK_IN);
        RESET_N_IN <= 1'b1;
        @(posedge CLK_IN);
        rchk("pull after reset", ADDR_PULL_EN_P, 32'h0);
        rchk("flags after reset", ADDR_FLAGS_P, 32'h0);
        $display("test second reset done");
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
